// ---- buck_fault_ctrl.sv ----
// fault counter, ramp sequencer and sync control of the buck supervisor
// Function
// - low-side overload adds one next cycle
// - low-side sense below limit subtracts one
// - count seven declares fault, drives off
// - drive-pin load picks multiplier 3/7/15
// - multiplier latched in calibration after power ok
// - high-side short loads seven, ends pulse
// - soft-start begins when calibration ends
// - boost charge on until ramp half volt
// - fast discharge in lockout, calibration, low rail
// - fault sinks ramp, recharges below low
// - fault below high charges to high first
// - soft-start limit is one and half
// - hot after charging declares thermal fault
// - thermal hiccup repeats until cooled
// - master drives half-duty sync pulses
// - master sync falls at high-side rise
// - grounded role starts on rising sync
// - open role starts on falling sync
// - lost sync runs slow, then free
// - run only with enable, rail, input ok
`include "buck_regs.svh"
`timescale 1ns/1ps
module buck_fault_ctrl
   import buck_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  anaIn_t           anaIn,
   output gate_t            gateDrive,
   output rampCtl_t         rampCtl,
   output logic             overcurrentFault,
   output logic             otFault,
   output logic      [3:0]  shortCircuitMultiplier,
   output logic             syncOut,
   output logic             syncOe_n
);

   localparam ctl_t CTL_RST = '{mode: M_OFF, period: `FREE_PERIOD_RST,
                                syncOe_n: 1'b1, default: '0};

   ctl_t        st_q;
   ctl_t        st_d;
   anaIn_t      lvl;
   anaIn_t      rise;
   anaIn_t      fall;
   logic        cycleStart;
   logic        halfPoint;
   logic [16:0] elapsed;
   logic        isMaster;
   logic        isSlave180;
   logic        qual;
   logic        powerOk;
   logic [15:0] fbLen;
   logic [15:0] curLen;
   logic        freeRun;
   logic [16:0] lossWin;
   logic        lossDet;
   logic        running;
   logic        blankDone;
   logic        hsTrip;
   logic        calDone;
   logic        switchOn;
   logic        mapped;
   logic [31:0] rdata;
   logic [31:0] status;

   // ----------------------------------------------------------------------
   // pin inputs and cycle timer
   // ----------------------------------------------------------------------
   edge_sync #(.W($bits(anaIn_t))) uSync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     (anaIn),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   cycle_timer uTimer (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .periodLen  (curLen),
      .freeRun    (freeRun),
      .restart    (qual),
      .cycleStart (cycleStart),
      .halfPoint  (halfPoint),
      .elapsed    (elapsed)
   );

   // ----------------------------------------------------------------------
   // role and sync decode
   // ----------------------------------------------------------------------
   assign isMaster   = lvl.roleTiedHigh;
   assign isSlave180 = !lvl.roleTiedHigh && lvl.roleTiedLow;
   assign qual    = !isMaster && (isSlave180 ? rise.syncPin : fall.syncPin);
   assign powerOk = lvl.enableOk && lvl.gateSupplyOk && lvl.inputUvOk;
   assign fbLen   = 16'((20'(st_q.period) * `FALLBACK_NUM) / `FALLBACK_DEN);
   assign curLen  = st_q.fallback ? fbLen : st_q.period;
   assign freeRun = isMaster || st_q.syncLost;
   assign lossWin = {1'b0, st_q.period} + {2'b00, st_q.period[15:1]};
   assign lossDet = !isMaster && !st_q.syncLost && (elapsed >= lossWin);

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   assign status = {12'h000, st_q.syncLost, st_q.fallback, isMaster,
                    isSlave180, st_q.mult, st_q.mode, st_q.otHold,
                    st_q.otFault, st_q.ocFault, st_q.faultCnt};
   assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS);
   always_comb
   begin
      if (paddr == `REG_CTRL)
         rdata = {16'h0000, st_q.period};
      else if (paddr == `REG_STATUS)
         rdata = status;
      else
         rdata = 32'h00000000;
   end
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = st_q.prdata;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   assign running   = ((st_q.mode == M_SOFT) || (st_q.mode == M_RUN))
                      && !st_q.ocFault && !st_q.otFault;
   assign blankDone = st_q.blank >= 8'(`BLANK_CYC);
   assign hsTrip    = running && st_q.hsOn && blankDone && lvl.hsOverShort;
   assign calDone   = (st_q.mode == M_CAL)
                      && (st_q.calCnt == 12'(`CAL_CYC - 1));

   always_comb
   begin
      st_d     = st_q;
      switchOn = 1'b0;
      if (psel && !penable)
         st_d.prdata = rdata;
      if (psel && penable && pwrite && (paddr == `REG_CTRL))
         st_d.period = pwdata[15:0];

      // sync loss and fallback
      if (qual)
      begin
         st_d.syncLost = 1'b0;
         st_d.fallback = 1'b0;
      end
      else if (lossDet)
      begin
         st_d.syncLost = 1'b1;
         st_d.fallback = 1'b1;
         st_d.fbCnt    = 10'h000;
      end
      else if (st_q.fallback)
      begin
         if (st_q.fbCnt == 10'(`FALLBACK_CYC - 1))
            st_d.fallback = 1'b0;
         else
            st_d.fbCnt = st_q.fbCnt + 10'h001;
      end

      // master sync output
      st_d.syncOe_n = !isMaster;
      if (!isMaster)
         st_d.syncOut = 1'b0;
      else if (cycleStart)
         st_d.syncOut = 1'b0;
      else if (halfPoint)
         st_d.syncOut = 1'b1;

      // hold clear first, so a new hot trip wins
      if (lvl.thermCool)
         st_d.otHold = 1'b0;

      // ramp sequencer
      unique case (st_q.mode)
         M_OFF:
            if (powerOk)
            begin
               st_d.mode   = M_CAL;
               st_d.calCnt = 12'h000;
            end
         M_CAL:
            if (calDone)
            begin
               st_d.mult  = lvl.res10k ? `MULT_10K :
                            (lvl.res20k ? `MULT_20K : `MULT_OPEN);
               st_d.mode  = M_SOFT;
               st_d.boost = 1'b1;
            end
            else
               st_d.calCnt = st_q.calCnt + 12'h001;
         M_SOFT:
            if (lvl.rampHigh)
            begin
               if (st_q.otHold && !lvl.thermCool)
               begin
                  st_d.otFault = 1'b1;
                  st_d.mode    = M_FDIS;
               end
               else
                  st_d.mode = M_RUN;
            end
         M_RUN:
            if (lvl.thermHot)
            begin
               st_d.otFault = 1'b1;
               st_d.otHold  = 1'b1;
               st_d.mode    = M_FDIS;
            end
         M_FCHG:
            if (lvl.rampHigh)
               st_d.mode = M_FDIS;
         M_FDIS:
            if (lvl.rampLow)
            begin
               st_d.ocFault  = 1'b0;
               st_d.otFault  = 1'b0;
               st_d.faultCnt = 3'h0;
               st_d.mode     = M_SOFT;
            end
      endcase
      if (lvl.rampHalf || (st_d.mode != M_SOFT))
         st_d.boost = 1'b0;

      // overload counter
      if (!blankDone)
         st_d.blank = st_q.blank + 8'h01;
      if (running)
      begin
         if (st_q.lsOn && blankDone)
         begin
            st_d.lsValid = 1'b1;
            if (lvl.lsOverLimit)
               st_d.lsOver = 1'b1;
         end
         if (hsTrip)
            st_d.faultCnt = `FAULT_CNT_MAX;
         else if (cycleStart && st_q.lsValid)
         begin
            if (st_q.lsOver && (st_q.faultCnt != `FAULT_CNT_MAX))
               st_d.faultCnt = st_q.faultCnt + 3'h1;
            else if (!st_q.lsOver && (st_q.faultCnt != 3'h0))
               st_d.faultCnt = st_q.faultCnt - 3'h1;
         end
         if (cycleStart)
         begin
            st_d.lsValid = 1'b0;
            st_d.lsOver  = 1'b0;
         end
         if (st_d.faultCnt == `FAULT_CNT_MAX)
         begin
            st_d.ocFault = 1'b1;
            st_d.mode    = (st_d.mode == M_SOFT) ? M_FCHG : M_FDIS;
         end
      end

      // gate drives
      switchOn = ((st_d.mode == M_SOFT) || (st_d.mode == M_RUN))
                 && !st_d.ocFault && !st_d.otFault;
      if (!switchOn)
      begin
         st_d.hsOn = 1'b0;
         st_d.lsOn = 1'b0;
      end
      else if (cycleStart)
      begin
         st_d.hsOn  = 1'b1;
         st_d.lsOn  = 1'b0;
         st_d.blank = 8'h00;
      end
      else if (st_q.hsOn && lvl.pwmTrip)
      begin
         st_d.hsOn  = 1'b0;
         st_d.lsOn  = 1'b1;
         st_d.blank = 8'h00;
      end

      // power conditions
      if (!powerOk)
      begin
         st_d.mode     = M_OFF;
         st_d.faultCnt = 3'h0;
         st_d.ocFault  = 1'b0;
         st_d.otFault  = 1'b0;
         st_d.otHold   = 1'b0;
         st_d.boost    = 1'b0;
         st_d.hsOn     = 1'b0;
         st_d.lsOn     = 1'b0;
         st_d.lsValid  = 1'b0;
         st_d.lsOver   = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         st_q <= CTL_RST;
      else
         st_q <= st_d;
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign gateDrive.highSideDrive = st_q.hsOn;
   assign gateDrive.lowSideDrive  = st_q.lsOn;
   assign rampCtl.boost   = st_q.boost;
   assign rampCtl.charge  = (st_q.mode == M_SOFT) || (st_q.mode == M_RUN)
                            || (st_q.mode == M_FCHG);
   assign rampCtl.sinkDis = st_q.mode == M_FDIS;
   assign rampCtl.fastDis = (st_q.mode == M_OFF) || (st_q.mode == M_CAL);
   assign rampCtl.ocScale = (st_q.mode == M_SOFT) && !lvl.rampHigh;
   assign overcurrentFault       = st_q.ocFault;
   assign otFault                = st_q.otFault;
   assign shortCircuitMultiplier = st_q.mult;
   assign syncOut                = st_q.syncOut;
   assign syncOe_n               = st_q.syncOe_n;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   cnt_up_a: assert property (
      (running && powerOk && !hsTrip && cycleStart && st_q.lsValid
       && st_q.lsOver && (st_q.faultCnt < 3'h6))
      |=> (st_q.faultCnt == $past(st_q.faultCnt) + 3'h1))
      else $error("overload count did not rise");

   cnt_down_a: assert property (
      (running && powerOk && !hsTrip && cycleStart && st_q.lsValid
       && !st_q.lsOver && (st_q.faultCnt != 3'h0))
      |=> (st_q.faultCnt == $past(st_q.faultCnt) - 3'h1))
      else $error("overload count did not fall");

   oc_off_a: assert property (
      (st_q.faultCnt == `FAULT_CNT_MAX)
      |-> (st_q.ocFault && !st_q.hsOn && !st_q.lsOn))
      else $error("count seven without fault and drives off");

   hs_trip_a: assert property (
      (hsTrip && powerOk)
      |=> (st_q.faultCnt == `FAULT_CNT_MAX) && !st_q.hsOn && st_q.ocFault)
      else $error("short did not end the high-side pulse");

   cal_end_a: assert property (
      (calDone && powerOk)
      |=> (st_q.mode == M_SOFT) && st_q.boost
          && (st_q.mult inside {`MULT_10K, `MULT_OPEN, `MULT_20K}))
      else $error("soft-start not entered after calibration");

   boost_off_a: assert property (
      (st_q.boost && lvl.rampHalf) |=> !st_q.boost)
      else $error("boost charge stayed on");

   fast_dis_a: assert property (
      !lvl.inputUvOk |=> rampCtl.fastDis [*2])
      else $error("ramp not fast discharged in lockout");

   restart_a: assert property (
      ((st_q.mode == M_FDIS) && lvl.rampLow && powerOk)
      |=> (st_q.mode == M_SOFT) && (st_q.faultCnt == 3'h0)
          && !st_q.ocFault && !st_q.otFault)
      else $error("restart did not clear the fault");

   hold_chg_a: assert property (
      (st_q.mode == M_FCHG)
      |-> rampCtl.charge && !rampCtl.sinkDis && !st_q.hsOn)
      else $error("fault charge phase wrong");

   ot_trip_a: assert property (
      ((st_q.mode == M_RUN) && lvl.thermHot && powerOk)
      |=> st_q.otFault && (st_q.mode == M_FDIS) && !st_q.hsOn)
      else $error("thermal fault not declared");

   sync_fall_a: assert property (
      (isMaster && cycleStart && $stable(isMaster)) |=> !st_q.syncOut)
      else $error("master sync not low at cycle start");

   slave_edge_a: assert property (
      (isSlave180 && rise.syncPin) |-> cycleStart)
      else $error("slave cycle did not follow sync edge");

   fallback_a: assert property (
      (lossDet && !qual) |=> st_q.fallback && (curLen == fbLen))
      else $error("fallback frequency not entered");

   off_a: assert property (
      !powerOk |=> (st_q.mode == M_OFF) && !st_q.hsOn && !st_q.lsOn)
      else $error("device stayed on without power conditions");

   restart_c: cover property (
      (st_q.mode == M_FDIS) ##[1:1000] (st_q.mode == M_SOFT));
   short_c: cover property (hsTrip);
   loss_c: cover property (lossDet ##[1:1000] !st_q.fallback);
   ot_c: cover property (st_q.otFault && (st_q.mode == M_FDIS));

endmodule : buck_fault_ctrl

// ---- buck_fault_ctrl_tb.sv ----
// self-checking bench of the buck supervisor
`timescale 1ns/1ps
module buck_fault_ctrl_tb
   import buck_pkg::*;
;
   // ----------------------------------------------------------------
   // signals, model tables, tasks
   // ----------------------------------------------------------------
   logic        clk_sys = 1'b0, rstn = 1'b0, syncRun = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, lfsr = 32'h87F81574;
   logic        pready, pslverr, err, overcurrentFault, otFault;
   logic        syncOut, syncOe_n, pwmTrip, syncPin, prevH;
   logic        ls = 1'b0, hs = 1'b0;
   logic [2:0]  pw = 3'h0, rampBits;
   logic [1:0]  th = 2'h1, role = 2'h0, res = 2'h0;
   logic [3:0]  shortCircuitMultiplier;
   anaIn_t      anaIn;
   gate_t       gateDrive;
   rampCtl_t    rampCtl;
   int          error_cnt = 0, samples_checked = 0, i, k, hi;
   int          mMult[3] = '{3, 7, 15};
   logic [1:0]  resTab[3] = '{2'h2, 2'h0, 2'h1};
   logic [2:0]  offTab[3] = '{3'h3, 3'h5, 3'h6};
   assign anaIn = {pw, ls, hs, pwmTrip, rampBits, th, role, res, syncPin};
   initial forever #10 clk_sys = ~clk_sys;
   buck_fault_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .anaIn(anaIn),
      .gateDrive(gateDrive), .rampCtl(rampCtl), .otFault(otFault),
      .overcurrentFault(overcurrentFault), .syncOut(syncOut),
      .shortCircuitMultiplier(shortCircuitMultiplier),
      .syncOe_n(syncOe_n));
   buck_stage_model stage (.clk_sys(clk_sys), .syncRun(syncRun),
      .rampCtl(rampCtl), .gateDrive(gateDrive), .rampBits(rampBits),
      .pwmTrip(pwmTrip), .syncPin(syncPin));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic results();
      if (error_cnt == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic waitMode(input logic [5:0] m);
      int n;
      n = 0;
      do
         apb(1'b0, 12'h004, 32'h0);
      while (q[11:6] !== m && ++n < 1500);
      chk("mode", m, q[11:6]);
   endtask : waitMode
   initial
   begin
      #2000000;
      error_cnt++;
      results();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", 32'hA6, q);
      apb(1'b1, 12'h004, lfsr);
      apb(1'b0, 12'h004, 32'h0);
      chk("status", 32'h40, q & 32'hFFFF);
      chk("fastDis", 1, rampCtl.fastDis);
      apb(1'b0, 12'h008, 32'h0);
      chk("slverr", 1, err);
      lfsr = nxt(lfsr);
      apb(1'b1, 12'h000, lfsr & 32'hFFFF);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", lfsr & 32'hFFFF, q);
      apb(1'b1, 12'h000, 32'hA6);
      k = lfsr % 3;
      for (i = 0; i < 3; i++)
      begin
         res <= resTab[(i + k) % 3];
         pw  <= 3'h7;
         waitMode(6'h02);
         chk("fastDis", 1, rampCtl.fastDis);
         waitMode(6'h04);
         chk("boost", 1, rampCtl.boost);
         chk("ocScale", 1, rampCtl.ocScale);
         res <= 2'h3;
         repeat (60) @(posedge clk_sys);
         chk("boost", 0, rampCtl.boost);
         chk("mult", mMult[(i + k) % 3], shortCircuitMultiplier);
         chk("oe", 1, syncOe_n);
         pw <= offTab[i];
         waitMode(6'h01);
         chk("drive", 0, gateDrive);
      end
      role <= 2'h2;
      pw   <= 3'h7;
      waitMode(6'h08);
      chk("ocScale", 0, rampCtl.ocScale);
      chk("oe", 0, syncOe_n);
      hi = 0;
      prevH = 1'b1;
      repeat (498)
      begin
         @(negedge clk_sys);
         hi += syncOut;
         if (gateDrive.highSideDrive && !prevH)
            chk("syncOut", 0, syncOut);
         prevH = gateDrive.highSideDrive;
      end
      chk("duty", 1, hi > 244 && hi < 254);
      apb(1'b0, 12'h004, 32'h0);
      ls <= 1'b1;
      waitMode(6'h20);
      chk("count", 7, q[2:0]);
      chk("oc", 1, overcurrentFault);
      chk("drive", 0, gateDrive);
      ls <= 1'b0;
      waitMode(6'h04);
      chk("count", 0, q[2:0]);
      waitMode(6'h08);
      hs <= 1'b1;
      waitMode(6'h20);
      chk("count", 7, q[2:0]);
      hs <= 1'b0;
      waitMode(6'h04);
      waitMode(6'h08);
      th <= 2'h2;
      waitMode(6'h20);
      chk("ot", 1, otFault);
      chk("drive", 0, gateDrive);
      waitMode(6'h04);
      waitMode(6'h20);
      chk("ot", 1, otFault);
      th <= 2'h1;
      waitMode(6'h08);
      chk("ot", 0, otFault);
      role    <= 2'h1;
      syncRun <= 1'b1;
      apb(1'b1, 12'h000, 32'h8);
      repeat (200) @(posedge clk_sys);
      apb(1'b0, 12'h004, 32'h0);
      chk("fallback", 0, q[18]);
      chk("oe", 1, syncOe_n);
      syncRun <= 1'b0;
      i = 0;
      do
         apb(1'b0, 12'h004, 32'h0);
      while (q[18] !== 1'b1 && ++i < 100);
      chk("fallback", 1, q[18]);
      repeat (1100) @(posedge clk_sys);
      apb(1'b0, 12'h004, 32'h0);
      chk("fallback", 0, q[18]);
      results();
   end
endmodule : buck_fault_ctrl_tb

// ---- buck_pkg.sv ----
// types shared by the buck supervisor modules
package buck_pkg;

   // ----------------------------------------------------------------------
   // ramp sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [5:0] {
      M_OFF  = 6'h01,
      M_CAL  = 6'h02,
      M_SOFT = 6'h04,
      M_RUN  = 6'h08,
      M_FCHG = 6'h10,
      M_FDIS = 6'h20
   } mode_t;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic enableOk;
      logic gateSupplyOk;
      logic inputUvOk;
      logic lsOverLimit;
      logic hsOverShort;
      logic pwmTrip;
      logic rampHalf;
      logic rampLow;
      logic rampHigh;
      logic thermHot;
      logic thermCool;
      logic roleTiedHigh;
      logic roleTiedLow;
      logic res10k;
      logic res20k;
      logic syncPin;
   } anaIn_t;

   typedef struct packed {
      logic highSideDrive;
      logic lowSideDrive;
   } gate_t;

   typedef struct packed {
      logic boost;
      logic charge;
      logic sinkDis;
      logic fastDis;
      logic ocScale;
   } rampCtl_t;

   // ----------------------------------------------------------------------
   // module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [16:0] cnt;
   } timer_t;

   typedef struct packed {
      mode_t       mode;
      logic [2:0]  faultCnt;
      logic        ocFault;
      logic        otFault;
      logic        otHold;
      logic        boost;
      logic        hsOn;
      logic        lsOn;
      logic [7:0]  blank;
      logic        lsValid;
      logic        lsOver;
      logic [11:0] calCnt;
      logic [3:0]  mult;
      logic        syncOut;
      logic        syncOe_n;
      logic        fallback;
      logic [9:0]  fbCnt;
      logic        syncLost;
      logic [15:0] period;
      logic [31:0] prdata;
   } ctl_t;

endpackage : buck_pkg

// ---- buck_regs.svh ----
// register offsets, reset values and timing counts of the buck supervisor
`ifndef BUCK_REGS_SVH
`define BUCK_REGS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define BLANK_NS 200
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_NS 40000
`define CAL_CYC (`CAL_NS / `CLK_PERIOD_NS)
`define FALLBACK_NS 20000
`define FALLBACK_CYC (`FALLBACK_NS / `CLK_PERIOD_NS)
`define FALLBACK_NUM 20'd10
`define FALLBACK_DEN 20'd7

// ----------------------------------------------------------------------
// fault counter and multipliers
// ----------------------------------------------------------------------
`define FAULT_CNT_MAX 3'h7
`define MULT_10K 4'h3
`define MULT_OPEN 4'h7
`define MULT_20K 4'hF

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define FREE_PERIOD_RST 16'h00A6

`endif

// ---- buck_stage_model.sv ----
// power stage model: ramp capacitor, pwm trip and sync source
`timescale 1ns/1ps
module buck_stage_model
   import buck_pkg::*;
(
   input  wire logic  clk_sys,
   input  wire logic  syncRun,
   input  rampCtl_t   rampCtl,
   input  gate_t      gateDrive,
   output logic [2:0] rampBits,
   output logic       pwmTrip,
   output logic       syncPin
);
   int mv = 0;
   int on = 0;
   // ----------------------------------------------------------------
   // ramp capacitor in millivolts, high-side on time
   // ----------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (rampCtl.fastDis)
         mv <= 0;
      else if (rampCtl.sinkDis)
         mv <= (mv > 5) ? mv - 5 : 0;
      else if (rampCtl.charge && mv < 3000)
         mv <= mv + (rampCtl.boost ? 20 : 5);
      on <= gateDrive.highSideDrive ? on + 1 : 0;
   end
   assign rampBits = {mv >= 500, mv < 300, mv >= 2500};
   assign pwmTrip  = on >= 14;
   // sync source, stands low when stopped
   initial
   begin
      syncPin = 1'b0;
      #7;
      forever #80 syncPin <= syncRun & !syncPin;
   end
endmodule : buck_stage_model

// ---- cycle_timer.sv ----
// switching cycle timer with external restart
`timescale 1ns/1ps
module cycle_timer
   import buck_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [15:0] periodLen,
   input  wire logic        freeRun,
   input  wire logic        restart,
   output logic             cycleStart,
   output logic             halfPoint,
   output logic      [16:0] elapsed
);

   timer_t st_q;
   timer_t st_d;
   logic   wrap;

   assign wrap       = freeRun && (st_q.cnt >= ({1'b0, periodLen} - 17'h1));
   assign cycleStart = restart | wrap;
   assign halfPoint  = st_q.cnt == {2'b00, periodLen[15:1]};
   assign elapsed    = st_q.cnt;

   always_comb
   begin
      st_d = st_q;
      if (cycleStart)
         st_d.cnt = 17'h0;
      else if (st_q.cnt != 17'h1FFFF)
         st_d.cnt = st_q.cnt + 17'h1;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

endmodule : cycle_timer

// ---- edge_sync.sv ----
// two-flop synchroniser with edge detection for every pin input
`timescale 1ns/1ps
module edge_sync #(
   parameter int W = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sync_t;

   sync_t st_q;
   sync_t st_d;

   always_comb
   begin
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // ----------------------------------------------------------------------
   // per-bit edges
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < W; i++)
   begin : gBit
      assign level[i] = st_q.s2[i];
      assign rise[i]  = st_q.s2[i] & ~st_q.s3[i];
      assign fall[i]  = ~st_q.s2[i] & st_q.s3[i];
   end

endmodule : edge_sync
